// ---- design/dds_host.sv ----
`timescale 1ns/100ps
// probe-side sequencer that drives dormant entry and wake-up sequences
module dds_host (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire logic [dds_pkg::CMD_W-1:0] cmd_code,
  output logic cmd_ready,
  output logic done,
  output logic shared_debug_clock,
  output logic shared_debug_data_mode_out,
  output logic shared_debug_data_mode_oe,
  input wire logic shared_debug_data_mode_in,
  output logic line_level
);
  import dds_pkg::*;

  typedef struct packed {
    dds_state_t st;
    logic [7:0] cnt;
    logic [127:0] pat;
    logic [7:0] plen;
    logic [11:0] code;
    logic [3:0] clen;
    logic [2:0] gap;
    logic [5:0] post;
    logic post_high;
    logic clk;
    logic dout;
    logic oe;
    logic rdy;
    logic done;
    logic sync1;
    logic sync2;
  } dds_host_reg_t;

  dds_host_reg_t r;
  dds_host_reg_t next_r;
  logic tick;
  logic accept;

  // ===========================================================
  // shared clock timing
  dds_tick_gen u_tick (
    .core_clk(core_clk),
    .nrst(nrst),
    .run(r.st != ST_IDLE),
    .tick(tick)
  );

  assign accept = (r.st == ST_IDLE) && cmd_valid;

  // ===========================================================
  // sequencer
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.sync1 = shared_debug_data_mode_in;
    next_r.sync2 = r.sync1;
    case (r.st)
      ST_IDLE: begin
        if (cmd_valid) begin
          next_r.gap = 3'h0;
          next_r.clen = 4'h0;
          next_r.code = 12'h000;
          next_r.post = 6'h00;
          next_r.post_high = 1'b0;
          next_r.dout = 1'b1;
          next_r.st = ST_PRE;
          case (cmd_code)
            CMD_SCAN_TO_DORMANT: begin
              // five high clocks reset tap, selecting idcode
              next_r.cnt = SCAN_PRE_BITS;
              next_r.pat = {SCAN_DORMANT_SEQ, 97'h0};
              next_r.plen = SCAN_DORMANT_LEN;
            end
            CMD_WIRE_TO_DORMANT: begin
              // line reset then pattern, two lows lead
              next_r.cnt = WIRE_PRE_BITS;
              next_r.pat = {WIRE_DORMANT_SEQ, 112'h0};
              next_r.plen = WIRE_DORMANT_LEN;
            end
            CMD_WAKE_SCAN_GENERIC, CMD_WAKE_SCAN_RESET: begin
              // idle by one low clock, or reset by five high
              next_r.cnt = WAKE_PRE_BITS;
              next_r.pat = ALERT_SEQ;
              next_r.plen = ALERT_LEN;
              next_r.gap = GAP_BITS;
              next_r.code = CODE_SCAN_GENERIC;
              next_r.clen = CODE_SCAN_GENERIC_LEN;
              if (cmd_code == CMD_WAKE_SCAN_RESET) begin
                next_r.post = POST_RESET_BITS;
                next_r.post_high = 1'b1;
              end else begin
                next_r.post = POST_IDLE_BITS;
              end
            end
            CMD_WAKE_SCAN_PORT: begin
              next_r.cnt = WAKE_PRE_BITS;
              next_r.pat = ALERT_SEQ;
              next_r.plen = ALERT_LEN;
              next_r.gap = GAP_BITS;
              next_r.code = {CODE_SCAN_PORT, 4'h0};
              next_r.clen = CODE_BYTE_LEN;
              next_r.post = POST_IDLE_BITS;
            end
            CMD_WAKE_WIRE: begin
              // fifty high clocks end in line reset
              next_r.cnt = WAKE_PRE_BITS;
              next_r.pat = ALERT_SEQ;
              next_r.plen = ALERT_LEN;
              next_r.gap = GAP_BITS;
              next_r.code = {CODE_WIRE, 4'h0};
              next_r.clen = CODE_BYTE_LEN;
              next_r.post = POST_WIRE_BITS;
              next_r.post_high = 1'b1;
            end
            default: begin
              // unknown command is dropped without any line activity
              next_r.st = ST_IDLE;
              next_r.dout = r.dout;
            end
          endcase
        end
      end
      ST_PRE, ST_PAT, ST_GAP, ST_CODE, ST_POST: begin
        if (tick && !r.clk) begin
          // rising edge: target samples the bit now standing
          next_r.clk = 1'b1;
        end else if (tick) begin
          // falling edge: present the next bit
          next_r.clk = 1'b0;
          if (r.cnt > 8'h01) begin
            next_r.cnt = r.cnt - 8'h01;
            case (r.st)
              ST_PAT: begin
                next_r.dout = r.pat[127];
                next_r.pat = {r.pat[126:0], 1'b0};
              end
              ST_CODE: begin
                next_r.dout = r.code[11];
                next_r.code = {r.code[10:0], 1'b0};
              end
              ST_GAP: next_r.dout = 1'b0;
              ST_POST: next_r.dout = r.post_high;
              default: next_r.dout = 1'b1;
            endcase
          end else begin
            case (r.st)
              ST_PRE: begin
                // alert or pattern follows preamble directly
                next_r.st = ST_PAT;
                next_r.cnt = r.plen;
                next_r.dout = r.pat[127];
                next_r.pat = {r.pat[126:0], 1'b0};
              end
              ST_PAT: begin
                if (r.gap != 3'h0) begin
                  // four low clocks after the alert
                  next_r.st = ST_GAP;
                  next_r.cnt = {5'h00, r.gap};
                  next_r.dout = 1'b0;
                end else begin
                  next_r.st = ST_IDLE;
                  next_r.done = 1'b1;
                  // line parks high once the pattern ends
                  next_r.dout = 1'b1;
                end
              end
              ST_GAP: begin
                // activation code straight after the gap
                next_r.st = ST_CODE;
                next_r.cnt = {4'h0, r.clen};
                next_r.dout = r.code[11];
                next_r.code = {r.code[10:0], 1'b0};
              end
              ST_CODE: begin
                next_r.st = ST_POST;
                next_r.cnt = {2'h0, r.post};
                next_r.dout = r.post_high;
              end
              default: begin
                next_r.st = ST_IDLE;
                next_r.done = 1'b1;
                next_r.dout = 1'b1;
              end
            endcase
          end
        end
      end
      default: begin
        next_r.st = ST_IDLE;
        next_r.clk = 1'b0;
      end
    endcase
    next_r.rdy = (next_r.st == ST_IDLE);
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      r.st <= ST_IDLE;
      r.cnt <= 8'h00;
      r.pat <= 128'h0;
      r.plen <= 8'h00;
      r.code <= 12'h000;
      r.clen <= 4'h0;
      r.gap <= 3'h0;
      r.post <= 6'h00;
      r.post_high <= 1'b0;
      r.clk <= 1'b0;
      r.dout <= 1'b1;
      r.oe <= 1'b1;
      r.rdy <= 1'b1;
      r.done <= 1'b0;
      r.sync1 <= 1'b0;
      r.sync2 <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign cmd_ready = r.rdy;
  assign done = r.done;
  assign shared_debug_clock = r.clk;
  assign shared_debug_data_mode_out = r.dout;
  assign shared_debug_data_mode_oe = r.oe;
  assign line_level = r.sync2;

  // ===========================================================
  // checks
  property p_scan_pre;
    @(posedge core_clk) disable iff (!nrst)
    accept && cmd_code == CMD_SCAN_TO_DORMANT |=>
      r.st == ST_PRE && r.cnt == 8'h05 && r.plen == 8'h1F;
  endproperty
  a_scan_pre: assert property (p_scan_pre)
    else $error("scan dormant preamble not five bits");

  property p_wire_pre;
    @(posedge core_clk) disable iff (!nrst)
    accept && cmd_code == CMD_WIRE_TO_DORMANT |=>
      r.cnt == 8'h32 && r.pat[127:126] == 2'b00 && r.pat[125];
  endproperty
  a_wire_pre: assert property (p_wire_pre)
    else $error("two-wire dormant pattern badly framed");

  property p_wake_pre;
    @(posedge core_clk) disable iff (!nrst)
    accept && cmd_code == CMD_WAKE_WIRE |=>
      r.cnt == 8'h08 && r.plen == 8'h80 && r.gap == 3'h4;
  endproperty
  a_wake_pre: assert property (p_wake_pre)
    else $error("wake preamble or alert length wrong");

  property p_wire_code;
    @(posedge core_clk) disable iff (!nrst)
    accept && cmd_code == CMD_WAKE_WIRE |=>
      r.code == 12'h580 && r.clen == 4'h8 && r.post == 6'h32;
  endproperty
  a_wire_code: assert property (p_wire_code)
    else $error("two-wire activation setup wrong");

  property p_gap_low;
    @(posedge core_clk) disable iff (!nrst)
    r.st == ST_GAP |-> !r.dout;
  endproperty
  a_gap_low: assert property (p_gap_low)
    else $error("line not low during gap");

  property p_pre_high;
    @(posedge core_clk) disable iff (!nrst)
    r.st == ST_PRE |-> r.dout && r.oe;
  endproperty
  a_pre_high: assert property (p_pre_high)
    else $error("line not high during preamble");

  property p_clock_on_tick;
    @(posedge core_clk) disable iff (!nrst)
    !tick |=> $stable(r.clk);
  endproperty
  a_clock_on_tick: assert property (p_clock_on_tick)
    else $error("shared clock moved without a tick");

  property p_data_stable_high;
    @(posedge core_clk) disable iff (!nrst)
    r.clk |=> $stable(r.dout) || $fell(r.clk);
  endproperty
  a_data_stable_high: assert property (p_data_stable_high)
    else $error("data changed while clock high");

  property p_done_idle;
    @(posedge core_clk) disable iff (!nrst)
    $rose(r.done) |-> r.st == ST_IDLE && r.rdy ##1 !r.done;
  endproperty
  a_done_idle: assert property (p_done_idle)
    else $error("done not a single idle pulse");

  property p_idle_line;
    @(posedge core_clk) disable iff (!nrst)
    r.st == ST_IDLE |-> !r.clk && r.dout;
  endproperty
  a_idle_line: assert property (p_idle_line)
    else $error("link not parked with clock low and line high");

  property p_gap_to_code;
    @(posedge core_clk) disable iff (!nrst)
    r.st == ST_GAP |=> r.st == ST_GAP || r.st == ST_CODE;
  endproperty
  a_gap_to_code: assert property (p_gap_to_code)
    else $error("activation code did not follow the gap");

endmodule : dds_host

// ---- design/dds_pkg.sv ----
package dds_pkg;

  // ===========================================================
  // command codes
  localparam int CMD_W = 3;
  localparam logic [2:0] CMD_SCAN_TO_DORMANT = 3'h0;
  localparam logic [2:0] CMD_WIRE_TO_DORMANT = 3'h1;
  localparam logic [2:0] CMD_WAKE_SCAN_GENERIC = 3'h2;
  localparam logic [2:0] CMD_WAKE_SCAN_PORT = 3'h3;
  localparam logic [2:0] CMD_WAKE_WIRE = 3'h4;
  localparam logic [2:0] CMD_WAKE_SCAN_RESET = 3'h5;

  // ===========================================================
  // sequencer states
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_PRE = 6'h02,
    ST_PAT = 6'h04,
    ST_GAP = 6'h08,
    ST_CODE = 6'h10,
    ST_POST = 6'h20
  } dds_state_t;

  // ===========================================================
  // link timing
  localparam int CORE_PERIOD_NS = 5;
  localparam int LINK_HALF_NS = 25;
  localparam int LINK_HALF_CYC_I =
    (LINK_HALF_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam logic [3:0] LINK_HALF_CYC = LINK_HALF_CYC_I[3:0];

  // ===========================================================
  // sequence lengths and values
  localparam logic [7:0] SCAN_PRE_BITS = 8'h05;
  localparam logic [7:0] WIRE_PRE_BITS = 8'h32;
  localparam logic [7:0] WAKE_PRE_BITS = 8'h08;
  localparam logic [30:0] SCAN_DORMANT_SEQ = 31'h2EEEEE6;
  localparam logic [7:0] SCAN_DORMANT_LEN = 8'h1F;
  localparam logic [15:0] WIRE_DORMANT_SEQ = 16'h3DC7;
  localparam logic [7:0] WIRE_DORMANT_LEN = 8'h10;
  // alert held as the lfsr stream
  localparam logic [127:0] ALERT_SEQ =
    128'h49CF9046_A9B4A161_97F5BBC7_45703D98;
  localparam logic [7:0] ALERT_LEN = 8'h80;
  localparam logic [2:0] GAP_BITS = 3'h4;
  localparam logic [11:0] CODE_SCAN_GENERIC = 12'h000;
  localparam logic [3:0] CODE_SCAN_GENERIC_LEN = 4'hC;
  localparam logic [7:0] CODE_WIRE = 8'h58;
  localparam logic [7:0] CODE_SCAN_PORT = 8'h50;
  localparam logic [3:0] CODE_BYTE_LEN = 4'h8;
  localparam logic [5:0] POST_IDLE_BITS = 6'h01;
  localparam logic [5:0] POST_RESET_BITS = 6'h05;
  localparam logic [5:0] POST_WIRE_BITS = 6'h32;

endpackage : dds_pkg

// ---- design/dds_tick_gen.sv ----
`timescale 1ns/100ps
// half-period timer for the probe-made shared clock
module dds_tick_gen (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic run,
  output logic tick
);
  import dds_pkg::*;

  typedef struct packed {
    logic [3:0] cnt;
    logic tick;
  } dds_tick_reg_t;

  dds_tick_reg_t r;
  dds_tick_reg_t next_r;

  always_comb begin
    next_r = r;
    next_r.tick = 1'b0;
    if (!run) begin
      next_r.cnt = 4'h0;
    end else if (r.cnt == LINK_HALF_CYC - 4'h1) begin
      next_r.cnt = 4'h0;
      next_r.tick = 1'b1;
    end else begin
      next_r.cnt = r.cnt + 4'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tick = r.tick;

endmodule : dds_tick_gen

// ---- test/dds_target_model.sv ----
`timescale 1ns/100ps
// ===========================================================
// dual-protocol target: scan, two-wire and dormant selection
module dds_target_model
  import dds_pkg::*;
(
  input wire logic nrst,
  input wire logic shared_debug_clock,
  input wire logic shared_debug_data_mode,
  output logic [1:0] mode,
  output logic [15:0] bit_count,
  output logic [3:0] tap_state
);
  localparam logic [1:0] M_SCAN = 2'h0;
  localparam logic [1:0] M_WIRE = 2'h1;
  localparam logic [1:0] M_DORM = 2'h2;
  logic [127:0] hist;
  logic [127:0] nh;
  logic [11:0] code;
  logic [11:0] nc;
  logic [3:0] gap;
  logic [3:0] ncode;
  logic armed;
  localparam logic [3:0] T_TLR = 4'h0;
  localparam logic [3:0] T_RTI = 4'h1;
  localparam logic [3:0] T_SDR = 4'h2;
  localparam logic [3:0] T_CDR = 4'h3;
  localparam logic [3:0] T_SHDR = 4'h4;
  localparam logic [3:0] T_E1DR = 4'h5;
  localparam logic [3:0] T_PDR = 4'h6;
  localparam logic [3:0] T_E2DR = 4'h7;
  localparam logic [3:0] T_UDR = 4'h8;
  localparam logic [3:0] T_SIR = 4'h9;
  localparam logic [3:0] T_CIR = 4'hA;
  localparam logic [3:0] T_SHIR = 4'hB;
  localparam logic [3:0] T_E1IR = 4'hC;
  localparam logic [3:0] T_PIR = 4'hD;
  localparam logic [3:0] T_E2IR = 4'hE;
  localparam logic [3:0] T_UIR = 4'hF;
  logic [3:0] nt;
  logic [2:0] zero_scan_counter;
  logic zero_scan_locked;
  logic shift_seen_flag;
  // tap controller step for one sample of the mode line
  function automatic logic [3:0] tap_next(input logic [3:0] s,
                                          input logic line_bit);
    case (s)
      T_TLR: tap_next = line_bit ? T_TLR : T_RTI;
      T_RTI: tap_next = line_bit ? T_SDR : T_RTI;
      T_SDR: tap_next = line_bit ? T_SIR : T_CDR;
      T_CDR: tap_next = line_bit ? T_E1DR : T_SHDR;
      T_SHDR: tap_next = line_bit ? T_E1DR : T_SHDR;
      T_E1DR: tap_next = line_bit ? T_UDR : T_PDR;
      T_PDR: tap_next = line_bit ? T_E2DR : T_PDR;
      T_E2DR: tap_next = line_bit ? T_UDR : T_SHDR;
      T_UDR: tap_next = line_bit ? T_SDR : T_RTI;
      T_SIR: tap_next = line_bit ? T_TLR : T_CIR;
      T_CIR: tap_next = line_bit ? T_E1IR : T_SHIR;
      T_SHIR: tap_next = line_bit ? T_E1IR : T_SHIR;
      T_E1IR: tap_next = line_bit ? T_UIR : T_PIR;
      T_PIR: tap_next = line_bit ? T_E2IR : T_PIR;
      T_E2IR: tap_next = line_bit ? T_UIR : T_SHIR;
      default: tap_next = line_bit ? T_SDR : T_RTI;
    endcase
  endfunction : tap_next
  assign nt = tap_next(tap_state, shared_debug_data_mode);
  assign nh = {hist[126:0], shared_debug_data_mode};
  assign nc = {code[10:0], shared_debug_data_mode};
  always_ff @(posedge shared_debug_clock or negedge nrst) begin
    if (!nrst) begin
      mode <= M_SCAN;
      // tap reset pin clears and unlocks the count
      tap_state <= T_TLR;
      zero_scan_counter <= 3'h0;
      zero_scan_locked <= 1'b0;
      shift_seen_flag <= 1'b0;
      bit_count <= 16'h0000;
      hist <= '1;
      armed <= 1'b0;
      gap <= 4'h0;
      ncode <= 4'h0;
      code <= 12'h000;
    end else begin
      hist <= nh;
      bit_count <= bit_count + 16'h0001;
      case (mode)
        M_SCAN: begin
          tap_state <= nt;
          case (nt)
            // a data scan starts clean at capture
            T_CDR: shift_seen_flag <= 1'b0;
            // a real shift locks a nonzero count
            T_SHDR: begin
              shift_seen_flag <= 1'b1;
              if (zero_scan_counter != 3'h0) zero_scan_locked <= 1'b1;
            end
            // count zero scans, saturate at seven
            T_UDR: begin
              if (!zero_scan_locked && !shift_seen_flag &&
                  zero_scan_counter != 3'h7) begin
                zero_scan_counter <= zero_scan_counter + 3'h1;
              end
            end
            T_SIR, T_TLR: begin
              zero_scan_counter <= 3'h0;
              zero_scan_locked <= 1'b0;
            end
            // six enters; five also, the short pattern locks there
            T_RTI: begin
              if (zero_scan_locked && (zero_scan_counter == 3'h6 ||
                  zero_scan_counter == 3'h5)) begin
                mode <= M_DORM;
                tap_state <= T_TLR;
                zero_scan_counter <= 3'h0;
                zero_scan_locked <= 1'b0;
              end
            end
            default: begin
            end
          endcase
        end
        M_WIRE: begin
          if (nh[65:0] == {{50{1'b1}}, WIRE_DORMANT_SEQ}) mode <= M_DORM;
        end
        default: begin
          if (!armed) begin
            if (nh == ALERT_SEQ) begin
              armed <= 1'b1;
              gap <= 4'h4;
              ncode <= 4'h0;
            end
          end else if (gap != 4'h0) begin
            gap <= gap - 4'h1;
          end else begin
            code <= nc;
            ncode <= ncode + 4'h1;
            if (ncode == 4'h7 && nc[7:0] == CODE_WIRE) begin
              mode <= M_WIRE;
              armed <= 1'b0;
            end else if (ncode == 4'h7 && nc[7:0] == CODE_SCAN_PORT) begin
              mode <= M_SCAN;
              armed <= 1'b0;
            end else if (ncode == 4'h7 && nc[7:0] != 8'h00) begin
              armed <= 1'b0;
            end else if (ncode == 4'hB) begin
              armed <= 1'b0;
              // tap resumes at idle or reset
              if (nc == CODE_SCAN_GENERIC) mode <= M_SCAN;
            end
          end
        end
      endcase
    end
  end
endmodule : dds_target_model

// ---- test/tb_dds_host.sv ----
`timescale 1ns/100ps
module tb_dds_host;
  import dds_pkg::*;
  logic core_clk, nrst, cmd_valid, cmd_ready, done;
  logic sclk, dout, doe, line, lvl;
  logic [CMD_W-1:0] cmd_code;
  logic [1:0] mode;
  logic [15:0] bits;
  logic [3:0] tap;
  int errors, samples_checked;
  // pull-up when the probe releases the line
  assign line = doe ? dout : 1'b1;
  dds_host DUT (.core_clk(core_clk), .nrst(nrst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_ready(cmd_ready), .done(done),
    .shared_debug_clock(sclk), .shared_debug_data_mode_out(dout),
    .shared_debug_data_mode_oe(doe), .shared_debug_data_mode_in(line),
    .line_level(lvl));
  dds_target_model tgt (.nrst(nrst), .shared_debug_clock(sclk),
    .shared_debug_data_mode(line), .mode(mode), .bit_count(bits),
    .tap_state(tap));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // ===========================================================
  // helpers
  task check(input string what, input logic [15:0] exp,
             input logic [15:0] got);
    samples_checked++;
    if (exp !== got) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task run_cmd(input string name, input logic [2:0] c,
               input logic [15:0] nbits, input logic [1:0] st,
               input bit poke);
    logic [15:0] start;
    int n;
    start = bits;
    cmd_valid = 1'b1;
    cmd_code = c;
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    check("ready after take", 16'h0000, {15'h0, cmd_ready});
    n = 0;
    while (done !== 1'b1 && n < 5000) begin
      if (poke && n == 20) begin
        cmd_valid = 1'b1;
        cmd_code = CMD_WAKE_WIRE;
      end else begin
        cmd_valid = 1'b0;
      end
      @(posedge core_clk);
      #1;
      n++;
    end
    cmd_valid = 1'b0;
    check("ready and done", 16'h0003, {14'h0, cmd_ready, done});
    check("bit count", nbits, bits - start);
    check("target mode", {14'h0, st}, {14'h0, mode});
    check("idle pins", 16'h0003, {13'h0, sclk, dout, doe});
    repeat (30) @(posedge core_clk);
    #1;
    check("no further bits", nbits, bits - start);
    $display("test %s done", name);
  endtask : run_cmd
  // ===========================================================
  // scenarios
  task t_bad_code;
    logic [15:0] start;
    start = bits;
    cmd_valid = 1'b1;
    cmd_code = 3'h6;
    repeat (3) @(posedge core_clk);
    #1;
    cmd_code = 3'h7;
    repeat (3) @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    repeat (30) @(posedge core_clk);
    #1;
    check("ready on bad code", 16'h0001, {15'h0, cmd_ready});
    check("bits on bad code", 16'h0000, bits - start);
    check("line level", 16'h0001, {15'h0, lvl});
    $display("test bad code done");
  endtask : t_bad_code
  task t_scan_entry(input bit poke);
    run_cmd("scan entry", CMD_SCAN_TO_DORMANT, 16'h0024, 2'h2, poke);
  endtask : t_scan_entry
  task t_dormant_ignores;
    run_cmd("dormant ignores", CMD_WIRE_TO_DORMANT, 16'h0042, 2'h2,
            1'b0);
  endtask : t_dormant_ignores
  task t_wake_wire;
    run_cmd("wake wire", CMD_WAKE_WIRE, 16'h00C6, 2'h1, 1'b0);
  endtask : t_wake_wire
  task t_wire_entry;
    run_cmd("wire entry", CMD_WIRE_TO_DORMANT, 16'h0042, 2'h2, 1'b0);
  endtask : t_wire_entry
  task t_wake_scan_port;
    run_cmd("wake scan port", CMD_WAKE_SCAN_PORT, 16'h0095, 2'h0,
            1'b0);
    check("tap idle after port code", 16'h0001, {12'h000, tap});
  endtask : t_wake_scan_port
  task t_wake_generic;
    run_cmd("wake generic", CMD_WAKE_SCAN_GENERIC, 16'h0099, 2'h0,
            1'b0);
    check("tap idle after generic", 16'h0001, {12'h000, tap});
  endtask : t_wake_generic
  task t_wake_reset;
    run_cmd("wake reset", CMD_WAKE_SCAN_RESET, 16'h009D, 2'h0,
            1'b0);
    check("tap reset after wake", 16'h0000, {12'h000, tap});
  endtask : t_wake_reset
  // ===========================================================
  // run control
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  initial begin
    #400000;
    errors++;
    $display("watchdog expired");
    finish_test;
  end
  initial begin
    errors = 0;
    samples_checked = 0;
    nrst = 1'b0;
    cmd_valid = 1'b0;
    cmd_code = 3'h0;
    repeat (12) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    t_bad_code;
    t_scan_entry(1'b1);
    t_dormant_ignores;
    t_wake_wire;
    t_wire_entry;
    t_wake_scan_port;
    t_scan_entry(1'b0);
    t_wake_generic;
    t_scan_entry(1'b0);
    t_wake_reset;
    finish_test;
  end
endmodule : tb_dds_host
